// ==== flash_ext_params_pkg.sv ====
// Types for the extended read parameter register
package flash_ext_params_pkg;
  typedef struct packed {
    logic [2:0] drive_sel;
    logic       learning_pattern_enable;
    logic       erase_err_flag;
    logic       program_err_flag;
    logic       protect_violation_flag;
    logic       reserved;
  } ext_params_s;
  typedef enum logic [2:0] {
    DRV_RSVD0, DRV_12P5, DRV_25, DRV_37P5, DRV_RSVD4, DRV_75, DRV_100, DRV_50
  } drive_e;
endpackage

// ==== flash_ext_params_regs.svh ====
// Constants for the read and extended read parameter registers
`ifndef FLASH_EXT_PARAMS_REGS_SVH
`define FLASH_EXT_PARAMS_REGS_SVH
`define OP_SET_RD_PERSIST   8'h65
`define OP_SET_RD_VOLAT_A   8'hC0
`define OP_SET_RD_VOLAT_B   8'h63
`define OP_SET_EXT_PERSIST  8'h85
`define OP_SET_EXT_VOLAT    8'h83
`define OP_CLEAR_ERR        8'h82
`define OP_READ_RD_PARAMS   8'h61
`define OP_READ_EXT_PARAMS  8'h81
`define RD_PARAMS_RESET     8'h00
`define EXT_PARAMS_RESET    8'hE0
`define EXT_WR_MASK         8'hF0
`define DUMMY_LSB           3
`define DUMMY_DEFAULT       4'h8
`endif

// ==== flash_ext_read_param_regs.sv ====
// Read and extended read parameter registers with sticky error flags
`timescale 1ns/1ns
`include "flash_ext_params_regs.svh"
module flash_ext_read_param_regs (
  input  wire logic       i_core_clk,     // Core clock, 100 MHz
  input  wire logic       i_rst,          // Async reset, high
  input  wire logic       i_sck,          // Link clock pin
  input  wire logic       i_cs_n,         // Chip select pin, low
  input  wire logic       i_si,           // Serial data in pin
  input  wire logic       i_program_fail, // Program failure pulse
  input  wire logic       i_erase_fail,   // Erase failure pulse
  input  wire logic       i_protect_fail, // Protection hit pulse
  input  wire logic       i_prot_is_erase,// Protection hit was erase
  input  wire logic       i_soft_reset,   // Software reset pulse
  output logic [3:0]      o_dummy_cycles, // Read dummy cycles
  output logic [2:0]      o_drive_sel,    // Output drive select
  output logic [6:0]      o_drive_pct,    // Drive strength in percent
  output logic            o_learn_en,     // Learning pattern enable
  output logic [7:0]      o_rd_params,    // Volatile read params
  output logic [7:0]      o_ext_params,   // Volatile ext params view
  output logic [7:0]      o_ext_persist   // Persistent ext copy
);
  logic       byte_vld;
  logic [7:0] rx_byte;
  logic       rx_first;
  logic       sel;
  spi_cmd_rx u_rx (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_sck      (i_sck),
    .i_cs_n     (i_cs_n),
    .i_si       (i_si),
    .o_byte_vld (byte_vld),
    .o_byte     (rx_byte),
    .o_first    (rx_first),
    .o_sel      (sel)
  );

  // ==========================================================
  // Command tracking
  logic [7:0] op_r;
  logic       data_done_r;
  logic [7:0] rd_nv_r;
  logic [7:0] rd_v_r;
  logic [7:0] ext_nv_r;
  logic [7:0] ext_v_r;
  logic [2:0] err_r;
  logic       boot_r;
  wire  op_vld  = byte_vld & rx_first;
  wire  dat_vld = byte_vld & ~rx_first & ~data_done_r;
  wire  w_ext_nv = dat_vld & (op_r == `OP_SET_EXT_PERSIST);
  wire  w_ext_v  = dat_vld & (op_r == `OP_SET_EXT_VOLAT);
  wire  w_rd_nv  = dat_vld & (op_r == `OP_SET_RD_PERSIST);
  wire  w_rd_v   = dat_vld & ((op_r == `OP_SET_RD_VOLAT_A) |
                              (op_r == `OP_SET_RD_VOLAT_B));
  wire  clr_err  = (op_vld & (rx_byte == `OP_CLEAR_ERR)) | i_soft_reset;
  // Only writable bits taken; flag and reserved positions dropped
  wire [7:0] ext_wdata = rx_byte & `EXT_WR_MASK;

  // ==========================================================
  // Error flags: set wins over clear
  wire       prot_set = i_protect_fail;
  wire [2:0] err_set = {i_erase_fail | (prot_set & i_prot_is_erase),
                        i_program_fail | (prot_set & ~i_prot_is_erase),
                        prot_set};
  wire [2:0] err_nxt = err_set | (clr_err ? 3'h0 : err_r);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      op_r        <= 8'h00;
      data_done_r <= 1'b0;
    end else if (!sel) begin
      data_done_r <= 1'b0;
    end else if (op_vld) begin
      op_r        <= rx_byte;
      data_done_r <= 1'b0;
    end else if (byte_vld) begin
      data_done_r <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_nv_r  <= `RD_PARAMS_RESET;
      ext_nv_r <= `EXT_PARAMS_RESET;
    end else begin
      if (w_rd_nv)
        rd_nv_r <= rx_byte;
      if (w_ext_nv)
        ext_nv_r <= ext_wdata;
    end
  end

  // Volatile copies reload from persistent copies after reset
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      boot_r  <= 1'b1;
      rd_v_r  <= `RD_PARAMS_RESET;
      ext_v_r <= `EXT_PARAMS_RESET;
    end else begin
      boot_r <= 1'b0;
      if (boot_r) begin
        rd_v_r  <= rd_nv_r;
        ext_v_r <= ext_nv_r;
      end else begin
        if (w_rd_v)
          rd_v_r <= rx_byte;
        if (w_ext_v)
          ext_v_r <= ext_wdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst)
      err_r <= 3'h0;
    else
      err_r <= err_nxt;
  end

  // ==========================================================
  // Decoded outputs
  function automatic logic [6:0] drive_pct(input logic [2:0] c);
    unique case (flash_ext_params_pkg::drive_e'(c))
      flash_ext_params_pkg::DRV_12P5: drive_pct = 7'h0c;
      flash_ext_params_pkg::DRV_25:   drive_pct = 7'h19;
      flash_ext_params_pkg::DRV_37P5: drive_pct = 7'h25;
      flash_ext_params_pkg::DRV_75:   drive_pct = 7'h4b;
      flash_ext_params_pkg::DRV_100:  drive_pct = 7'h64;
      flash_ext_params_pkg::DRV_50:   drive_pct = 7'h32;
      default:                        drive_pct = 7'h00;
    endcase
  endfunction

  flash_ext_params_pkg::ext_params_s ext_view;
  wire [3:0] dummy_code = rd_v_r[`DUMMY_LSB+3:`DUMMY_LSB];
  wire [3:0] dummy_nxt  = (dummy_code == 4'h0) ? `DUMMY_DEFAULT
                                               : dummy_code;
  always_comb begin
    ext_view                         = ext_v_r;
    ext_view.erase_err_flag          = err_r[2];
    ext_view.program_err_flag        = err_r[1];
    ext_view.protect_violation_flag  = err_r[0];
    ext_view.reserved                = 1'b0;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dummy_cycles <= `DUMMY_DEFAULT;
      o_drive_sel    <= 3'h7;
      o_drive_pct    <= 7'h32;
      o_learn_en     <= 1'b0;
      o_rd_params    <= `RD_PARAMS_RESET;
      o_ext_params   <= `EXT_PARAMS_RESET;
      o_ext_persist  <= `EXT_PARAMS_RESET;
    end else begin
      o_dummy_cycles <= dummy_nxt;
      o_drive_sel    <= ext_view.drive_sel;
      o_drive_pct    <= drive_pct(ext_view.drive_sel);
      o_learn_en     <= ext_view.learning_pattern_enable;
      o_rd_params    <= rd_v_r;
      o_ext_params   <= ext_view;
      o_ext_persist  <= ext_nv_r;
    end
  end
endmodule

// ==== flash_ext_read_param_regs_tb.sv ====
// Self-checking bench for the extended parameter registers
`timescale 1ns/1ns
module flash_ext_read_param_regs_tb;
  localparam logic [6:0] PCT [8] = '{7'h00, 7'h0c, 7'h19, 7'h25,
                                     7'h00, 7'h4b, 7'h64, 7'h32};
  logic clk = 1'b0, rst = 1'b1, pgm = 1'b0, ers = 1'b0, prt = 1'b0;
  logic prt_ers = 1'b0, srst = 1'b0, learn;
  logic [3:0] dummy;
  logic [2:0] drv;
  logic [6:0] pct;
  logic [7:0] rd, ext, pers, d, e;
  wire sck, cs_n, si;
  int num_errors = 0, num_checks = 0;
  always #5 clk = ~clk;
  spi_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));
  flash_ext_read_param_regs uut (.i_core_clk(clk), .i_rst(rst),
    .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_program_fail(pgm),
    .i_erase_fail(ers), .i_protect_fail(prt), .i_prot_is_erase(prt_ers),
    .i_soft_reset(srst), .o_dummy_cycles(dummy), .o_drive_sel(drv),
    .o_drive_pct(pct), .o_learn_en(learn), .o_rd_params(rd),
    .o_ext_params(ext), .o_ext_persist(pers));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] dt, int n);
    host.xfer({op, dt}, n);
    repeat (12) @(negedge clk);
  endtask
  // Event pulse: {program, erase, protect, soft reset}
  task automatic pulse(input logic [3:0] v);
    @(negedge clk);
    {pgm, ers, prt, srst} = v;
    @(negedge clk);
    {pgm, ers, prt, srst} = 4'h0;
    repeat (5) @(negedge clk);
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
  initial begin
    void'($urandom(84));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(ext, 8'he0);
    chk(pers, 8'he0);
    chk({4'h0, dummy}, 8'h08);
    chk({1'b0, pct}, 8'h32);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom());
      d[7:5] = 3'(i);
      cmd(8'h83, d, 16);
      e = {d[7:4], 4'h0};
      chk(ext, e);
      chk({5'h0, drv}, {5'h0, d[7:5]});
      chk({1'b0, pct}, {1'b0, PCT[i]});
      chk({7'h0, learn}, {7'h0, d[4]});
      chk(pers, 8'he0);
    end
    d = 8'($urandom());
    cmd(8'h85, d, 16);
    chk(pers, {d[7:4], 4'h0});
    chk(ext, e);
    $display("test ext writes done");
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom());
      d[6:3] = 4'(i);
      cmd(i[0] ? 8'hc0 : 8'h63, d, 16);
      chk(rd, d);
      chk({4'h0, dummy}, {4'h0, i == 0 ? 4'h8 : 4'(i)});
    end
    // Persistent write must leave the volatile copy alone
    cmd(8'h65, ~d, 16);
    chk(rd, d);
    // Frame cut short mid data byte
    cmd(8'h63, 8'hff, 12);
    chk(rd, d);
    $display("test dummy done");
    prt_ers = 1'b1;
    pulse(4'h2);
    chk(ext, e | 8'h0a);
    pulse(4'h8);
    chk(ext, e | 8'h0e);
    cmd(8'h83, 8'h10, 16);
    chk(ext, 8'h1e);
    cmd(8'h82, 8'h00, 8);
    chk(ext, 8'h10);
    prt_ers = 1'b0;
    pulse(4'h2);
    chk(ext, 8'h16);
    pulse(4'h4);
    chk(ext, 8'h1e);
    pulse(4'h1);
    chk(ext, 8'h10);
    $display("test flags done");
    pulse(4'h4);
    chk(ext, 8'h18);
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(ext, 8'he0);
    chk(pers, 8'he0);
    chk({4'h0, dummy}, 8'h08);
    $display("test hard reset done");
    end_sim;
  end
endmodule

// ==== flash_ext_regs_assertions.sv ====
// Assertion checker for the extended parameter registers
`timescale 1ns/1ns
module flash_ext_regs_chk (
  input wire logic       i_core_clk,      // Clock
  input wire logic       i_rst,           // Reset
  input wire logic       i_program_fail,  // Program fail
  input wire logic       i_erase_fail,    // Erase fail
  input wire logic       i_protect_fail,  // Protect fail
  input wire logic       i_prot_is_erase, // Protect kind
  input wire logic [3:0] o_dummy_cycles,  // Dummy count
  input wire logic [2:0] o_drive_sel,     // Drive code
  input wire logic [6:0] o_drive_pct,     // Drive percent
  input wire logic       o_learn_en,      // Learn enable
  input wire logic [7:0] o_rd_params,     // Read params
  input wire logic [7:0] o_ext_params,    // Ext params
  input wire logic [7:0] o_ext_persist    // Ext persistent
);
  localparam logic [6:0] PCT [8] = '{7'h00, 7'h0c, 7'h19, 7'h25,
                                     7'h00, 7'h4b, 7'h64, 7'h32};
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_rd_still;
    $stable(o_rd_params) [*2];
  endsequence
  sequence s_ext_still;
    $stable(o_ext_params) [*2];
  endsequence
  a_dummy_map: assert property (s_rd_still |-> o_dummy_cycles ==
    (o_rd_params[6:3] == 4'h0 ? 4'h8 : o_rd_params[6:3]))
    else $error("dummy count wrong");
  a_drive_field: assert property (s_ext_still |->
    o_drive_sel == o_ext_params[7:5]) else $error("drive sel wrong");
  a_drive_pct: assert property ($stable(o_drive_sel) |->
    o_drive_pct == PCT[o_drive_sel]) else $error("drive pct wrong");
  a_rsvd_zero: assert property (o_ext_params[0] == 1'b0)
    else $error("reserved bit set");
  a_learn_field: assert property (s_ext_still |->
    o_learn_en == o_ext_params[4]) else $error("learn enable wrong");
  a_prog_flag: assert property (i_program_fail |->
    ##2 o_ext_params[2] [*4]) else $error("program flag missing");
  a_erase_flag: assert property (i_erase_fail |->
    ##2 o_ext_params[3]) else $error("erase flag missing");
  a_prot_flags: assert property (i_protect_fail |-> ##2
    o_ext_params[1] && o_ext_params[$past(i_prot_is_erase, 2) ? 3 : 2])
    else $error("protect flags missing");
  a_persist_flags: assert property (o_ext_persist[3:0] == 4'h0)
    else $error("persistent flags set");
endmodule
bind flash_ext_read_param_regs flash_ext_regs_chk chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_program_fail(i_program_fail), .i_erase_fail(i_erase_fail),
  .i_protect_fail(i_protect_fail), .i_prot_is_erase(i_prot_is_erase),
  .o_dummy_cycles(o_dummy_cycles), .o_drive_sel(o_drive_sel),
  .o_drive_pct(o_drive_pct), .o_learn_en(o_learn_en),
  .o_rd_params(o_rd_params), .o_ext_params(o_ext_params),
  .o_ext_persist(o_ext_persist));

// ==== spi_cmd_rx.sv ====
// Serial command and data byte receiver, SPI mode 0
`timescale 1ns/1ns
module spi_cmd_rx (
  input  wire logic       i_core_clk, // Core clock
  input  wire logic       i_rst,      // Async reset, high
  input  wire logic       i_sck,      // Link clock, raw pin
  input  wire logic       i_cs_n,     // Chip select, raw, low
  input  wire logic       i_si,       // Serial in, raw pin
  output logic            o_byte_vld, // Byte done pulse
  output logic [7:0]      o_byte,     // Received byte
  output logic            o_first,    // Byte is the opcode
  output logic            o_sel       // Synced select active
);
  logic [2:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] si_s;
  logic [7:0] sh_r;
  logic [2:0] cnt_r;
  logic       first_r;
  wire        rise = sck_s[1] & ~sck_s[2];
  wire        act  = ~cs_s[1];
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sck_s <= 3'h0;
      cs_s  <= 2'h3;
      si_s  <= 2'h0;
    end else begin
      sck_s <= {sck_s[1:0], i_sck};
      cs_s  <= {cs_s[0], i_cs_n};
      si_s  <= {si_s[0], i_si};
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_r       <= 8'h00;
      cnt_r      <= 3'h0;
      first_r    <= 1'b1;
      o_byte_vld <= 1'b0;
      o_byte     <= 8'h00;
      o_first    <= 1'b0;
    end else begin
      o_byte_vld <= 1'b0;
      if (!act) begin
        cnt_r   <= 3'h0;
        first_r <= 1'b1;
      end else if (rise) begin
        sh_r  <= {sh_r[6:0], si_s[1]};
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h7) begin
          o_byte_vld <= 1'b1;
          o_byte     <= {sh_r[6:0], si_s[1]};
          o_first    <= first_r;
          first_r    <= 1'b0;
        end
      end
    end
  end
  assign o_sel = act;
endmodule

// ==== spi_host_model.sv ====
// Link host model driving mode 0 command frames
`timescale 1ns/1ns
module spi_host_model (
  output logic o_sck,  // Link clock
  output logic o_cs_n, // Select, low
  output logic o_si    // Serial data
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // Opcode then data, MSB first; n bits sent
  task automatic xfer(input logic [15:0] bits, input int n);
    // Offset keeps every pin edge clear of core clock edges
    #2;
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_si = bits[15-i];
      #62 o_sck = 1'b1;
      #63 o_sck = 1'b0;
    end
    #62 o_cs_n = 1'b1;
    o_si = ~o_si;
  endtask
endmodule
